// ---- hdl/usrf_framer.sv ----
`timescale 1ns/100ps
// What this block does
// - Send confirmation for each slot request
// - Send indication with final request outcome
// - Octet 0 carries sender node number
// - Octet 1 carries domain designator
// - Octets 2-7 carry cluster number
// - Octets 8-13 carry governing master registration
// - Octets 14-16 carry network domain number
// - Confirmation octet 17 carries coordination table
// - Confirmation octet 18 carries transaction number
// - Indication octets 17-18 carry same fields
// - Confirmation codes: 0 ok, 1 fail, 2 refrain
// - Octet 20 counts refrain allocation periods
// - Refrain octet present only for code 2
// - Master refrains requests for signalled periods
// - Indication codes: 0 ok, 1 fail only
// - Request octet 18 holds echoed transaction
module usrf_framer
    import usrf_pkg::*;
#(
    // Header octets ahead of the outcome code
    parameter int HEADER_OCTETS = 19
)
(
    // Clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic CE,
    // Identity of this node
    input wire logic [7:0] SENDER_NODE_NUMBER,
    input wire logic [7:0] SENDER_DOMAIN_DESIGNATOR,
    input wire logic [47:0] SENDER_CLUSTER_NUMBER,
    input wire logic [47:0] GOVERNING_MASTER_REGISTRATION,
    input wire logic [23:0] NETWORK_DOMAIN_NUMBER,
    // Reply request from management logic
    input wire logic SEND_REQ,
    input wire usrf_pkg::usrf_kind_e SEND_KIND,
    input wire logic [7:0] COORDINATION_TABLE_NUMBER,
    input wire logic [7:0] TRANSACTION_NUMBER,
    input wire logic [7:0] OUTCOME_CODE,
    input wire logic [7:0] REFRAIN_PERIOD_COUNT,
    output logic SEND_BUSY,
    output logic SEND_DONE,
    // Link
    usrf_link_if.sender LINK
);
    import usrf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [167:0] hdr_reg, hdr_next;
    logic [7:0] code_reg, code_next;
    logic [7:0] refrain_reg, refrain_next;
    usrf_kind_e kind_reg, kind_next;
    logic [4:0] idx_reg, idx_next;
    logic [4:0] len_reg, len_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic valid_reg, valid_next;
    logic [7:0] data_reg, data_next;
    logic last_reg, last_next;
    logic [7:0] safe_code;
    logic [7:0] cur_octet;
    logic [4:0] send_len;

    // Header register must hold every octet ahead of the outcome
    if (HEADER_OCTETS != int'(USRF_OFS_OUTCOME) || HEADER_OCTETS * 8 > 168)
    begin : g_size_check
        $error("header length does not fit the register");
    end

    ////////////////////////////////////////////////////////////////////////
    // Reserved codes replaced by failure before sending
    always_comb
    begin
        safe_code = OUTCOME_CODE;
        if (SEND_KIND == USRF_KIND_IND && OUTCOME_CODE > USRF_OC_FAILURE)
        begin
            safe_code = USRF_OC_FAILURE;
        end
        if (SEND_KIND == USRF_KIND_CNF && OUTCOME_CODE > USRF_OC_REFRAIN)
        begin
            safe_code = USRF_OC_FAILURE;
        end
    end

    // Octet select: header shifts out MSB octet first
    always_comb
    begin
        cur_octet = hdr_reg[167:160];
        if (idx_reg == USRF_OFS_OUTCOME)
        begin
            cur_octet = code_reg;
        end
        else if (idx_reg == USRF_OFS_REFRAIN)
        begin
            cur_octet = refrain_reg;
        end
    end

    // Refrain octet only follows a refrain confirmation
    always_comb
    begin
        send_len = USRF_LEN_BASE;
        if (SEND_KIND == USRF_KIND_CNF && safe_code == USRF_OC_REFRAIN)
        begin
            send_len = USRF_LEN_REFRAIN;
        end
    end

    always_comb
    begin
        hdr_next = hdr_reg;
        code_next = code_reg;
        refrain_next = refrain_reg;
        kind_next = kind_reg;
        idx_next = idx_reg;
        len_next = len_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        valid_next = valid_reg;
        data_next = data_reg;
        last_next = last_reg;
        if (!busy_reg)
        begin
            if (SEND_REQ)
            begin
                hdr_next = {SENDER_NODE_NUMBER,
                    SENDER_DOMAIN_DESIGNATOR,
                    SENDER_CLUSTER_NUMBER,
                    GOVERNING_MASTER_REGISTRATION,
                    NETWORK_DOMAIN_NUMBER,
                    COORDINATION_TABLE_NUMBER,
                    TRANSACTION_NUMBER,
                    16'h0000};
                code_next = safe_code;
                refrain_next = REFRAIN_PERIOD_COUNT;
                kind_next = SEND_KIND;
                len_next = send_len;
                idx_next = USRF_OFS_NODE;
                busy_next = 1'b1;
            end
        end
        else if (!valid_reg || LINK.ready)
        begin
            if (valid_reg && last_reg)
            begin
                valid_next = 1'b0;
                last_next = 1'b0;
                busy_next = 1'b0;
                done_next = 1'b1;
            end
            else
            begin
                valid_next = 1'b1;
                data_next = cur_octet;
                last_next = (idx_reg == len_reg - 5'h01);
                idx_next = idx_reg + 5'h01;
                if (idx_reg < USRF_OFS_OUTCOME)
                begin
                    hdr_next = {hdr_reg[159:0], 8'h00};
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            hdr_reg <= '0;
            code_reg <= 8'h00;
            refrain_reg <= 8'h00;
            kind_reg <= USRF_KIND_CNF;
            idx_reg <= 5'h00;
            len_reg <= USRF_LEN_BASE;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            valid_reg <= 1'b0;
            data_reg <= 8'h00;
            last_reg <= 1'b0;
        end
        else if (CE)
        begin
            hdr_reg <= hdr_next;
            code_reg <= code_next;
            refrain_reg <= refrain_next;
            kind_reg <= kind_next;
            idx_reg <= idx_next;
            len_reg <= len_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            valid_reg <= valid_next;
            data_reg <= data_next;
            last_reg <= last_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from registers
    assign SEND_BUSY = busy_reg;
    assign SEND_DONE = done_reg;
    assign LINK.valid = valid_reg;
    assign LINK.data = data_reg;
    assign LINK.last = last_reg;
    assign LINK.kind = kind_reg;
endmodule

// ---- hdl/usrf_pkg.sv ----
package usrf_pkg;
    typedef logic [7:0] usrf_octet_t;
    typedef enum logic [0:0]
    {
        USRF_KIND_CNF = 1'b0,
        USRF_KIND_IND = 1'b1
    } usrf_kind_e;
    localparam logic [4:0] USRF_OFS_NODE = 5'h00;
    localparam logic [4:0] USRF_OFS_DOMAIN = 5'h01;
    localparam logic [4:0] USRF_OFS_CLUSTER = 5'h02;
    localparam logic [4:0] USRF_OFS_MASTER = 5'h08;
    localparam logic [4:0] USRF_OFS_NETDOM = 5'h0E;
    localparam logic [4:0] USRF_OFS_TABLE = 5'h11;
    localparam logic [4:0] USRF_OFS_TRANS = 5'h12;
    localparam logic [4:0] USRF_OFS_OUTCOME = 5'h13;
    localparam logic [4:0] USRF_OFS_REFRAIN = 5'h14;
    localparam logic [4:0] USRF_LEN_BASE = 5'h14;
    localparam logic [4:0] USRF_LEN_REFRAIN = 5'h15;
    localparam logic [7:0] USRF_OC_SUCCESS = 8'h00;
    localparam logic [7:0] USRF_OC_FAILURE = 8'h01;
    localparam logic [7:0] USRF_OC_REFRAIN = 8'h02;
endpackage

// ---- hdl/usrf_link_if.sv ----
`timescale 1ns/100ps
interface usrf_link_if;
    import usrf_pkg::*;
    // One octet per beat, valid/ready, last marks final octet
    logic valid;
    logic ready;
    usrf_octet_t data;
    logic last;
    usrf_kind_e kind;
    modport sender (output valid, output data, output last, output kind,
        input ready);
    modport receiver (input valid, input data, input last, input kind,
        output ready);
endinterface

// ---- hdl/usrf_parser.sv ----
`timescale 1ns/100ps
module usrf_parser
    import usrf_pkg::*;
(
    // Clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic CE,
    // Link
    usrf_link_if.receiver LINK,
    // Decoded message
    output logic MSG_VALID,
    output usrf_pkg::usrf_kind_e MSG_KIND,
    output logic [7:0] SENDER_NODE_NUMBER,
    output logic [7:0] SENDER_DOMAIN_DESIGNATOR,
    output logic [47:0] SENDER_CLUSTER_NUMBER,
    output logic [47:0] GOVERNING_MASTER_REGISTRATION,
    output logic [23:0] NETWORK_DOMAIN_NUMBER,
    output logic [7:0] COORDINATION_TABLE_NUMBER,
    output logic [7:0] TRANSACTION_NUMBER,
    output logic [7:0] OUTCOME_CODE,
    output logic MSG_SUCCESS,
    output logic MSG_REFRAIN,
    output logic [7:0] REFRAIN_PERIOD_COUNT,
    output logic MSG_LENGTH_ERROR
);
    import usrf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [167:0] hdr_reg, hdr_next;
    logic [7:0] code_reg, code_next;
    logic [7:0] refrain_reg, refrain_next;
    logic [4:0] idx_reg, idx_next;
    logic vld_reg, vld_next;
    usrf_kind_e kind_reg, kind_next;
    logic succ_reg, succ_next;
    logic rfr_reg, rfr_next;
    logic err_reg, err_next;

    always_comb
    begin
        hdr_next = hdr_reg;
        code_next = code_reg;
        refrain_next = refrain_reg;
        idx_next = idx_reg;
        vld_next = 1'b0;
        kind_next = kind_reg;
        succ_next = succ_reg;
        rfr_next = rfr_reg;
        err_next = err_reg;
        if (LINK.valid)
        begin
            if (idx_reg < USRF_OFS_OUTCOME)
            begin
                hdr_next = {hdr_reg[159:0], LINK.data};
            end
            else if (idx_reg == USRF_OFS_OUTCOME)
            begin
                code_next = LINK.data;
            end
            else if (idx_reg == USRF_OFS_REFRAIN)
            begin
                refrain_next = LINK.data;
            end
            if (idx_reg != 5'h1F)
            begin
                idx_next = idx_reg + 5'h01;
            end
            if (LINK.last)
            begin
                idx_next = 5'h00;
                vld_next = 1'b1;
                kind_next = LINK.kind;
                // Reserved codes count as failure
                succ_next = (code_next == USRF_OC_SUCCESS);
                rfr_next = (LINK.kind == USRF_KIND_CNF)
                    && (code_next == USRF_OC_REFRAIN);
                err_next = (idx_reg + 5'h01 != ((LINK.kind == USRF_KIND_CNF
                    && code_next == USRF_OC_REFRAIN)
                    ? USRF_LEN_REFRAIN : USRF_LEN_BASE));
            end
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            hdr_reg <= '0;
            code_reg <= 8'h00;
            refrain_reg <= 8'h00;
            idx_reg <= 5'h00;
            vld_reg <= 1'b0;
            kind_reg <= USRF_KIND_CNF;
            succ_reg <= 1'b0;
            rfr_reg <= 1'b0;
            err_reg <= 1'b0;
        end
        else if (CE)
        begin
            hdr_reg <= hdr_next;
            code_reg <= code_next;
            refrain_reg <= refrain_next;
            idx_reg <= idx_next;
            vld_reg <= vld_next;
            kind_reg <= kind_next;
            succ_reg <= succ_next;
            rfr_reg <= rfr_next;
            err_reg <= err_next;
        end
    end

    // Receiver never stalls
    assign LINK.ready = 1'b1;
    assign MSG_VALID = vld_reg;
    assign MSG_KIND = kind_reg;
    // Header octets shift in at the bottom, octet 0 ends highest
    assign SENDER_NODE_NUMBER = hdr_reg[151:144];
    assign SENDER_DOMAIN_DESIGNATOR = hdr_reg[143:136];
    assign SENDER_CLUSTER_NUMBER = hdr_reg[135:88];
    assign GOVERNING_MASTER_REGISTRATION = hdr_reg[87:40];
    assign NETWORK_DOMAIN_NUMBER = hdr_reg[39:16];
    assign COORDINATION_TABLE_NUMBER = hdr_reg[15:8];
    assign TRANSACTION_NUMBER = hdr_reg[7:0];
    assign OUTCOME_CODE = code_reg;
    assign MSG_SUCCESS = succ_reg;
    assign MSG_REFRAIN = rfr_reg;
    assign REFRAIN_PERIOD_COUNT = refrain_reg;
    assign MSG_LENGTH_ERROR = err_reg;
endmodule

// ---- dv/usrf_assertions.sv ----
`timescale 1ns/100ps
module usrf_assertions
    import usrf_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // Link
    input wire logic valid,
    input wire logic ready,
    input wire usrf_pkg::usrf_octet_t data,
    input wire logic last,
    input wire usrf_pkg::usrf_kind_e kind
);
    import usrf_pkg::*;
    logic [4:0] idx_reg, idx_next;
    logic [7:0] code_reg, code_next;
    logic beat;
    assign beat = valid && ready;
    always_comb
    begin
        idx_next = idx_reg;
        code_next = code_reg;
        if (beat)
        begin
            idx_next = last ? 5'h00 : idx_reg + 5'h01;
            if (idx_reg == USRF_OFS_OUTCOME)
                code_next = data;
        end
    end
    always_ff @(posedge CLK_SYS)
    begin
        idx_reg <= SRST ? 5'h00 : idx_next;
        code_reg <= SRST ? 8'h00 : code_next;
    end
    //////////////////////////////////////////////////////
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    frame_length_a:
    assert property (beat && last |-> idx_reg == 5'h13 || idx_reg == 5'h14)
        else $error("frame ends at wrong octet");
    refrain_octet_a:
    assert property (beat && last && idx_reg == 5'h14
        |-> kind == USRF_KIND_CNF && code_reg == USRF_OC_REFRAIN)
        else $error("extra octet without refrain code");
    refrain_code_a:
    assert property (beat && idx_reg == 5'h13 && kind == USRF_KIND_CNF
        && data == USRF_OC_REFRAIN |-> !last)
        else $error("refrain count missing");
    code_range_a:
    assert property (beat && idx_reg == 5'h13
        |-> data <= (kind == USRF_KIND_CNF ? 8'h02 : 8'h01))
        else $error("reserved outcome code sent");
    kind_steady_a:
    assert property (beat && !last |=> !valid || $stable(kind))
        else $error("kind changed inside frame");
    end_gap_a:
    assert property (beat && last |=> !valid)
        else $error("no gap after frame end");
    octets_close_a:
    assert property (beat && !last |=> valid)
        else $error("hole inside frame");
    index_bound_a:
    assert property (beat |-> idx_reg < 5'h15)
        else $error("frame too long");
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    import usrf_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic req = 1'b0;
    usrf_kind_e kind = USRF_KIND_CNF;
    logic [7:0] node = 8'h00, dom = 8'h00, tbl = 8'h00, trn = 8'h00;
    logic [7:0] code = 8'h00, rfc = 8'h00;
    logic [47:0] clus = 48'h0, mreg = 48'h0;
    logic [23:0] ndom = 24'h0;
    logic busy, done, p_vld, p_ok, p_rf, p_le, b_vld, b_ok, b_le;
    usrf_kind_e p_kind;
    logic [7:0] p_node, p_dom, p_tbl, p_trn, p_code, p_rfc;
    logic [47:0] p_clus, p_mreg;
    logic [23:0] p_ndom;
    logic [171:0] em;
    logic [171:0] exp_msg[$];
    logic [7:0] exp_oct[$], seen[$];
    logic [1:0] exp_bad[$];
    int failures = 0, samples_checked = 0;
    usrf_link_if link ();
    usrf_link_if bad_link ();
    always #50 clk_sys = ~clk_sys;
    usrf_framer i_usrf_framer (.CLK_SYS(clk_sys), .SRST(srst), .CE(ce),
        .SENDER_NODE_NUMBER(node), .SENDER_DOMAIN_DESIGNATOR(dom),
        .SENDER_CLUSTER_NUMBER(clus), .GOVERNING_MASTER_REGISTRATION(mreg),
        .NETWORK_DOMAIN_NUMBER(ndom), .SEND_REQ(req), .SEND_KIND(kind),
        .COORDINATION_TABLE_NUMBER(tbl), .TRANSACTION_NUMBER(trn),
        .OUTCOME_CODE(code), .REFRAIN_PERIOD_COUNT(rfc), .SEND_BUSY(busy),
        .SEND_DONE(done), .LINK(link.sender));
    usrf_parser i_usrf_parser (.CLK_SYS(clk_sys), .SRST(srst), .CE(ce),
        .LINK(link.receiver), .MSG_VALID(p_vld), .MSG_KIND(p_kind),
        .SENDER_NODE_NUMBER(p_node), .SENDER_DOMAIN_DESIGNATOR(p_dom),
        .SENDER_CLUSTER_NUMBER(p_clus), .GOVERNING_MASTER_REGISTRATION(p_mreg),
        .NETWORK_DOMAIN_NUMBER(p_ndom), .COORDINATION_TABLE_NUMBER(p_tbl),
        .TRANSACTION_NUMBER(p_trn), .OUTCOME_CODE(p_code), .MSG_SUCCESS(p_ok),
        .MSG_REFRAIN(p_rf), .REFRAIN_PERIOD_COUNT(p_rfc),
        .MSG_LENGTH_ERROR(p_le));
    usrf_parser i_usrf_parser_bad (.CLK_SYS(clk_sys), .SRST(srst), .CE(ce),
        .LINK(bad_link.receiver), .MSG_VALID(b_vld), .MSG_KIND(),
        .SENDER_NODE_NUMBER(), .SENDER_DOMAIN_DESIGNATOR(),
        .SENDER_CLUSTER_NUMBER(), .GOVERNING_MASTER_REGISTRATION(),
        .NETWORK_DOMAIN_NUMBER(), .COORDINATION_TABLE_NUMBER(),
        .TRANSACTION_NUMBER(), .OUTCOME_CODE(), .MSG_SUCCESS(b_ok),
        .MSG_REFRAIN(), .REFRAIN_PERIOD_COUNT(), .MSG_LENGTH_ERROR(b_le));
    usrf_assertions i_usrf_assertions (.CLK_SYS(clk_sys), .SRST(srst),
        .valid(link.valid), .ready(link.ready), .data(link.data),
        .last(link.last), .kind(link.kind));
    ////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("Checked %0d, failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [171:0] e, g);
        samples_checked++;
        if (e !== g)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic put(input logic [47:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            exp_oct.push_back(v[8 * i +: 8]);
    endtask
    // Called at a falling edge; returns in the done cycle
    task automatic send(input usrf_kind_e k, input logic [7:0] c);
        logic [7:0] oc;
        logic rf;
        int n;
        {node, dom, tbl, trn, rfc} = 40'({$urandom, $urandom});
        clus = 48'({$urandom, $urandom});
        mreg = 48'({$urandom, $urandom});
        ndom = 24'($urandom);
        kind = k;
        code = c;
        req = 1'b1;
        oc = (c > (k == USRF_KIND_CNF ? 8'h02 : 8'h01)) ? 8'h01 : c;
        rf = (k == USRF_KIND_CNF) && (oc == USRF_OC_REFRAIN);
        put(node, 1);
        put(dom, 1);
        put(clus, 6);
        put(mreg, 6);
        put(ndom, 3);
        put(tbl, 1);
        put(trn, 1);
        put(oc, 1);
        if (rf)
            put(rfc, 1);
        exp_msg.push_back({k, node, dom, clus, mreg, ndom, tbl, trn, oc,
            oc == 8'h00, rf, rf ? rfc : 8'h00, 1'b0});
        @(negedge clk_sys);
        req = 1'b0;
        check("busy after request", 1'b1, busy);
        @(negedge clk_sys);
        req = 1'b1;
        tbl = ~tbl;
        @(negedge clk_sys);
        req = 1'b0;
        for (n = 0; n < 40 && done !== 1'b1; n++)
            @(negedge clk_sys);
        check("done", 1'b1, done);
        check("busy after done", 1'b0, busy);
    endtask
    task automatic send_bad(input usrf_kind_e k, input logic [7:0] c,
        input int n, input logic [1:0] e);
        exp_bad.push_back(e);
        bad_link.kind = k;
        for (int i = 0; i < n; i++)
        begin
            bad_link.valid = 1'b1;
            bad_link.data = (i == 19) ? c : 8'($urandom);
            bad_link.last = (i == n - 1);
            @(negedge clk_sys);
        end
        bad_link.valid = 1'b0;
        bad_link.last = 1'b0;
        bad_link.data = ~bad_link.data;
        @(negedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////
    always @(negedge clk_sys)
    begin
        if (link.valid === 1'b1 && link.ready === 1'b1)
            seen.push_back(link.data);
        if (p_vld === 1'b1)
        begin
            em = exp_msg.pop_front();
            check("message", em, {p_kind, p_node,
                p_dom, p_clus, p_mreg, p_ndom, p_tbl, p_trn, p_code,
                p_ok, p_rf, p_rf ? p_rfc : 8'h00, p_le});
            repeat (em[9] ? 21 : 20)
                check("octet", exp_oct.pop_front(), seen.pop_front());
        end
        if (b_vld === 1'b1)
            check("bad frame", exp_bad.pop_front(), {b_ok, b_le});
    end
    initial
    begin
        bad_link.valid = 1'b0;
        bad_link.data = 8'h00;
        bad_link.last = 1'b0;
        bad_link.kind = USRF_KIND_CNF;
        void'($urandom(32'hF74CCFD1));
        repeat (10) @(negedge clk_sys);
        srst = 1'b0;
        // Request held while frozen must not be taken
        ce = 1'b0;
        req = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("frozen busy", 1'b0, busy);
        ce = 1'b1;
        for (int i = 0; i < 36; i++)
            send(usrf_kind_e'(i % 2),
                (i < 12) ? 8'(i / 2) : 8'($urandom));
        send_bad(USRF_KIND_CNF, 8'h07, 20, 2'b00);
        send_bad(USRF_KIND_IND, 8'h02, 20, 2'b00);
        send_bad(USRF_KIND_CNF, 8'h00, 21, 2'b11);
        repeat (30) @(negedge clk_sys);
        close_out();
    end
    initial
    begin
        repeat (4000) @(posedge clk_sys);
        failures++;
        close_out();
    end
endmodule
